// file: rtl/move_exec_cfg.svh
// constants for the move and no-operation execute block
`ifndef MOVE_EXEC_CFG_SVH
`define MOVE_EXEC_CFG_SVH
`define ME_OPC_COPY      6'h08
`define ME_OPC_STORE     7'h01
`define ME_OPC_LIT_HI    4'hc
`define ME_NOP_WORD      14'h0000
`define ME_NOP_MASK      14'h3f9f
`define ME_DEST_BIT      7
`define ME_ACC_RESET     8'h00
`define ME_ZERO_RESET    1'b0
`endif

// file: rtl/move_exec_pkg.sv
// types for the move and no-operation execute block
package move_exec_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_COPY,
        OP_STORE,
        OP_LITERAL,
        OP_NOP
    } move_op_e;
endpackage

// file: rtl/move_decode_if.sv
// decoded instruction fields passed from decoder to executor
`timescale 1ns/10ps
interface move_decode_if;
    import move_exec_pkg::*;
    move_op_e   op;
    logic [6:0] faddr;
    logic       dest;
    logic [7:0] literal;
    modport dec (output op, output faddr, output dest, output literal);
    modport exe (input op, input faddr, input dest, input literal);
endinterface

// file: rtl/move_decoder.sv
// 14-bit instruction word decoder for the move group
`timescale 1ns/10ps
`include "move_exec_cfg.svh"
module move_decoder
    import move_exec_pkg::*;
(
    // instruction
    input  wire logic [13:0] instr,
    input  wire logic        instr_valid,
    // decoded fields
    move_decode_if.dec       dec
);
    always_comb begin
        dec.op      = OP_NONE;
        dec.faddr   = instr[6:0];
        dec.dest    = instr[`ME_DEST_BIT];
        // bits 9:8 of a literal word are don't-care
        dec.literal = instr[7:0];
        if (instr_valid) begin
            if (instr[13:10] == `ME_OPC_LIT_HI) begin
                dec.op = OP_LITERAL;
            end else if (instr[13:8] == `ME_OPC_COPY) begin
                dec.op = OP_COPY;
            end else if (instr[13:7] == `ME_OPC_STORE) begin
                dec.op = OP_STORE;
            end else if ((instr & `ME_NOP_MASK) == `ME_NOP_WORD) begin
                dec.op = OP_NOP;
            end
        end
    end
endmodule

// file: rtl/move_instruction_execute.sv
// execute stage for file copy, accumulator store, literal load and no-op
`timescale 1ns/10ps
`include "move_exec_cfg.svh"
// Overview of operation
// - copy file register to accumulator when dest is 0, back to itself when 1
// - copy updates zero flag from moved value; self-copy acts as zero test
// - store writes accumulator to file register, flags unchanged, one cycle
// - literal load puts 8-bit immediate in accumulator, flags unchanged
// - literal encoding's unused bits are ignored by the decoder
module move_instruction_execute
    import move_exec_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // instruction from fetch
    input  wire logic [13:0] instr,
    input  wire logic        instr_valid,
    // file register read port
    output logic      [6:0]  file_raddr,
    input  wire logic [7:0]  file_rdata,
    // file register write port
    output logic             file_we,
    output logic      [6:0]  file_waddr,
    output logic      [7:0]  file_wdata,
    // accumulator and zero flag
    output logic      [7:0]  acc,
    output logic             zero_flag,
    output logic             zero_we,
    // completion
    output logic             instr_done,
    output logic             pc_advance
);
    // decoded fields from the move decoder
    move_decode_if dif ();

    move_decoder u_dec (
        .instr       (instr),
        .instr_valid (instr_valid),
        .dec         (dif.dec)
    );

    // registered state and its next value
    logic [7:0] acc_r,   acc_nxt;
    logic       zero_r,  zero_nxt;
    logic       zwe_r,   zwe_nxt;
    logic       fwe_r,   fwe_nxt;
    logic [6:0] fwa_r,   fwa_nxt;
    logic [7:0] fwd_r,   fwd_nxt;
    logic       done_r,  done_nxt;

    // read is combinational so every instruction finishes in one cycle
    assign file_raddr = dif.faddr;

    // a write still in flight to the same register wins over the file read
    logic [7:0] moved_val;
    assign moved_val = (fwe_r && (fwa_r == dif.faddr)) ? fwd_r : file_rdata;

    // accumulator: copy with dest 0 or literal load
    always_comb begin
        acc_nxt = acc_r;
        case (dif.op)
            OP_COPY: begin
                if (!dif.dest) begin
                    acc_nxt = moved_val;
                end else begin
                    acc_nxt = acc_r;
                end
            end
            OP_STORE: begin
                acc_nxt = acc_r;
            end
            OP_LITERAL: begin
                acc_nxt = dif.literal;
            end
            OP_NOP: begin
                acc_nxt = acc_r;
            end
            OP_NONE: begin
                acc_nxt = acc_r;
            end
            default: begin
                acc_nxt = acc_r;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= `ME_ACC_RESET;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // zero flag: only the copy touches status, it holds between copies
    always_comb begin
        zero_nxt = zero_r;
        zwe_nxt  = 1'b0;
        case (dif.op)
            OP_COPY: begin
                zwe_nxt  = 1'b1;
                zero_nxt = (moved_val == 8'h00);
            end
            OP_STORE: begin
                zwe_nxt  = 1'b0;
                zero_nxt = zero_r;
            end
            OP_LITERAL: begin
                zwe_nxt  = 1'b0;
                zero_nxt = zero_r;
            end
            OP_NOP: begin
                zwe_nxt  = 1'b0;
                zero_nxt = zero_r;
            end
            OP_NONE: begin
                zwe_nxt = 1'b0;
            end
            default: begin
                zwe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            zero_r <= `ME_ZERO_RESET;
            zwe_r  <= 1'b0;
        end else begin
            zero_r <= zero_nxt;
            zwe_r  <= zwe_nxt;
        end
    end

    // file write port: store, or copy with dest 1
    always_comb begin
        fwe_nxt = 1'b0;
        fwa_nxt = fwa_r;
        fwd_nxt = fwd_r;
        case (dif.op)
            OP_COPY: begin
                if (dif.dest) begin
                    fwe_nxt = 1'b1;
                    fwa_nxt = dif.faddr;
                    fwd_nxt = moved_val;
                end else begin
                    fwe_nxt = 1'b0;
                end
            end
            OP_STORE: begin
                fwe_nxt = 1'b1;
                fwa_nxt = dif.faddr;
                fwd_nxt = acc_r;
            end
            OP_LITERAL: begin
                fwe_nxt = 1'b0;
            end
            OP_NOP: begin
                fwe_nxt = 1'b0;
            end
            OP_NONE: begin
                fwe_nxt = 1'b0;
            end
            default: begin
                fwe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fwe_r <= 1'b0;
            fwa_r <= 7'h00;
            fwd_r <= 8'h00;
        end else begin
            fwe_r <= fwe_nxt;
            fwa_r <= fwa_nxt;
            fwd_r <= fwd_nxt;
        end
    end

    // completion pulse for every recognised move-group word
    always_comb begin
        done_nxt = 1'b0;
        case (dif.op)
            OP_COPY: begin
                done_nxt = 1'b1;
            end
            OP_STORE: begin
                done_nxt = 1'b1;
            end
            OP_LITERAL: begin
                done_nxt = 1'b1;
            end
            OP_NOP: begin
                done_nxt = 1'b1;
            end
            OP_NONE: begin
                done_nxt = 1'b0;
            end
            default: begin
                done_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

    // outputs straight from flip-flops
    assign acc        = acc_r;
    assign zero_flag  = zero_r;
    assign zero_we    = zwe_r;
    assign file_we    = fwe_r;
    assign file_waddr = fwa_r;
    assign file_wdata = fwd_r;
    assign instr_done = done_r;
    // program counter steps once per finished word
    assign pc_advance = done_r;
endmodule

// file: testbench/move_exec_properties.sv
// assertions for the move execute block
`timescale 1ns/10ps
module move_exec_properties (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // watched ports
    input wire logic [13:0] instr,
    input wire logic        instr_valid,
    input wire logic [7:0]  file_rdata,
    input wire logic        file_we,
    input wire logic [6:0]  file_waddr,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  acc,
    input wire logic        zero_flag,
    input wire logic        zero_we,
    input wire logic        instr_done
);
    // value a copy moves: a write landing this edge to the same register wins
    logic [7:0] moved_val;
    assign moved_val = (file_we && file_waddr == instr[6:0]) ? file_wdata : file_rdata;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_copy_to_acc: assert property (instr_valid && instr[13:7] == 7'h10
        |=> acc == $past(moved_val) && instr_done) else $error("copy to acc");
    a_copy_zero_test: assert property (instr_valid && instr[13:8] == 6'h08
        |=> zero_we && zero_flag == ($past(moved_val) == 8'h00)) else $error("zero");
    a_copy_to_file: assert property (instr_valid && instr[13:7] == 7'h11
        |=> file_we && file_waddr == $past(instr[6:0]) && file_wdata == $past(moved_val))
        else $error("copy to file");
    a_store_acc: assert property (instr_valid && instr[13:7] == 7'h01
        |=> file_we && !zero_we && file_wdata == $past(acc)
            && file_waddr == $past(instr[6:0])) else $error("store");
    a_literal_load: assert property (instr_valid && instr[13:10] == 4'hc
        |=> acc == $past(instr[7:0]) && !zero_we && !file_we) else $error("literal");
    a_nop_quiet: assert property (instr_valid && (instr & 14'h3f9f) == 14'h0000
        |=> instr_done && !file_we && !zero_we && $stable(acc)) else $error("no-op");
endmodule
bind move_instruction_execute move_exec_properties u_chk (.core_clk, .rst_b, .instr,
    .instr_valid, .file_rdata, .file_we, .file_waddr, .file_wdata, .acc, .zero_flag,
    .zero_we, .instr_done);

// file: testbench/file_reg_model.sv
// file register model, combinational read
`timescale 1ns/10ps
module file_reg_model (
    // clock and ports
    input wire logic       core_clk,
    input wire logic [6:0] raddr,
    output logic     [7:0] rdata,
    input wire logic       we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    assign rdata = mem[raddr];
    always @(posedge core_clk) if (we) mem[waddr] <= wdata;
endmodule

// file: testbench/tb_top.sv
// random self-checking bench for the move execute block
`timescale 1ns/10ps
module tb_top;
    logic core_clk, rst_b, instr_valid, we, zf, zwe, done, pca, d, pd, gap;
    logic [13:0] instr;
    logic [6:0]  ra, wa, f, pf;
    logic [7:0]  rd, wd, acc, ea, sh [128];
    logic [9:0]  kk, pkk;
    logic [2:0]  kind, pk;
    int          num_errors, compares, cyc, seed;
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    move_instruction_execute dut (.core_clk, .rst_b, .instr, .instr_valid, .file_raddr(ra),
        .file_rdata(rd), .file_we(we), .file_waddr(wa), .file_wdata(wd), .acc,
        .zero_flag(zf), .zero_we(zwe), .instr_done(done), .pc_advance(pca));
    file_reg_model u_regs (.core_clk, .raddr(ra), .rdata(rd), .we, .waddr(wa), .wdata(wd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [13:0] enc(input logic [2:0] kd, input logic dd,
                                        input logic [6:0] ff, input logic [9:0] k);
        case (kd)
            3'd0: return {6'h08, dd, ff};
            3'd1: return {7'h01, ff};
            3'd2: return {4'hc, k};
            3'd3: return {7'h00, k[1:0], 5'h00};
            default: return {3'h5, k, 1'b0};
        endcase
    endfunction
    function automatic logic writes_file(input logic [2:0] kd, input logic dd);
        return kd == 3'd1 || (kd == 3'd0 && dd);
    endfunction
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        seed = 32'hb9f2bb85;
        rst_b = 1'b0;
        instr = 14'h0000;
        instr_valid = 1'b0;
        ea = 8'h00;
        kind = 3'd0;
        f = 7'h00;
        d = 1'b0;
        kk = 10'h000;
        for (int i = 0; i < 128; i++) sh[i] = 8'(i * 37);
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        instr <= enc(kind, d, f, kk);
        instr_valid <= 1'b1;
        for (int n = 0; n < 600; n++) begin
            pk = kind;
            pd = d;
            pf = f;
            pkk = kk;
            kind = (n < 9) ? 3'((n + 1) % 5) : 3'($unsigned($random(seed)) % 5);
            f = (n < 9) ? 7'h00 : 7'($random(seed));
            d = 1'($random(seed));
            kk = 10'($random(seed));
            gap = (n < 10) ? 1'b1 : 1'($random(seed));
            // store then copy of the same register with no idle cycle between
            if (pk == 3'd1 && n % 4 == 0 && n >= 10) begin
                kind = 3'd0;
                f = pf;
                gap = 1'b0;
            end
            @(posedge core_clk);
            instr <= gap ? 14'($random(seed)) : enc(kind, d, f, kk);
            instr_valid <= !gap;
            @(negedge core_clk);
            chk_bit(done, pk != 3'd4);
            chk_bit(pca, pk != 3'd4);
            chk_bit(we, writes_file(pk, pd));
            chk_bit(zwe, pk == 3'd0);
            if (pk == 3'd0) chk_bit(zf, sh[pf] == 8'h00);
            if (we === 1'b1) chk(wd, (pk == 3'd1) ? ea : sh[pf]);
            if (we === 1'b1) chk({1'b0, wa}, {1'b0, pf});
            if (pk == 3'd0 && !pd) ea = sh[pf];
            if (pk == 3'd1) sh[pf] = ea;
            if (pk == 3'd2) ea = pkk[7:0];
            chk(acc, ea);
            if (gap) begin
                @(posedge core_clk);
                instr <= enc(kind, d, f, kk);
                instr_valid <= 1'b1;
            end
        end
        give_verdict();
    end
endmodule
